// >>> core/poh_pkg.sv
// shared constants and types for the path overhead insertion control
package poh_pkg;
  localparam int unsigned ADDR_W = 16;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PAYLOAD = 12'h781;
  localparam logic [11:0] IDX_GROWTH = 12'h782;
  localparam logic [11:0] IDX_SRC = 12'h783;
  localparam logic [11:0] IDX_C2 = 12'h79b;
  localparam logic [11:0] IDX_G1 = 12'h79f;
  localparam logic [11:0] IDX_F2 = 12'h7a3;
  localparam logic [11:0] IDX_H4 = 12'h7a7;
  localparam logic [11:0] IDX_Z3 = 12'h7ab;
  localparam logic [11:0] IDX_Z4 = 12'h7af;
  localparam logic [11:0] IDX_Z5 = 12'h7b3;
  localparam logic [11:0] IDX_STATUS = 12'h7b7;
  // growth byte source control bit positions
  localparam int unsigned GB_Z5 = 3;
  localparam int unsigned GB_Z4 = 2;
  localparam int unsigned GB_Z3 = 1;
  localparam int unsigned GB_H4 = 0;
  localparam logic [7:0] GB_MASK = 8'h0f;
  localparam logic [7:0] PT_MASK = 8'h03;
  // overhead source control bit positions
  localparam int unsigned SRC_F2 = 7;
  localparam int unsigned SRC_REI_LSB = 5;
  localparam int unsigned SRC_RDI_LSB = 3;
  localparam int unsigned SRC_C2 = 2;
  localparam int unsigned SRC_AUTO = 1;
  localparam int unsigned SRC_AIS = 0;
  // outbound G1 field positions
  localparam int unsigned G1_REI_LSB = 4;
  localparam int unsigned G1_RDI_LSB = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] PDI_CODE = 8'hfc;
  localparam logic [7:0] AIS_BYTE = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PT_LTE = 2'b00,
    PT_ASYNC_E1 = 2'b01,
    PT_RSV2 = 2'b10,
    PT_RSV3 = 2'b11
  } payload_type_t;

  typedef enum logic [1:0] {
    G1_RX_A = 2'b00,
    G1_REG = 2'b01,
    G1_PIN = 2'b10,
    G1_RX_B = 2'b11
  } g1_src_t;

  typedef enum logic [3:0] {
    K_TOH = 4'h0,
    K_PTR = 4'h1,
    K_PAYLOAD = 4'h2,
    K_J1 = 4'h3,
    K_B3 = 4'h4,
    K_C2 = 4'h5,
    K_G1 = 4'h6,
    K_F2 = 4'h7,
    K_H4 = 4'h8,
    K_Z3 = 4'h9,
    K_Z4 = 4'ha,
    K_Z5 = 4'hb
  } byte_kind_t;

  typedef struct packed {
    byte_kind_t kind;
    logic [7:0] data;
  } beat_t;
endpackage

// >>> core/oh_deser.sv
// serial overhead input deserialiser, msb first
`timescale 1ns/10ps
`default_nettype none
module oh_deser #(
  parameter int unsigned W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_in,
  input wire logic bit_en,
  input wire logic sync,
  output logic [W-1:0] byte_q
);
  localparam int unsigned CW = $clog2(W);

  typedef struct packed {
    logic [W-1:0] shift;
    logic [CW-1:0] cnt;
    logic [W-1:0] word;
  } deser_t;

  deser_t s;
  deser_t n;

  initial begin
    if (W < 2) begin
      $error("oh_deser: W must be at least 2");
    end
  end

  always_comb begin
    n = s;
    if (bit_en) begin
      n.shift = {s.shift[W-2:0], bit_in};
      // sync marks the first bit of a byte
      if (sync) begin
        n.cnt = CW'(1);
      end else if (s.cnt == CW'(W - 1)) begin
        n.cnt = '0;
        n.word = {s.shift[W-2:0], bit_in};
      end else begin
        n.cnt = s.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign byte_q = s.word;
endmodule
`default_nettype wire

// >>> core/poh_insert_ctrl.sv
// transmit vc-3 path overhead insertion with axi4-lite control registers
// Contract
// [RULE1] two-bit payload type: 00 lte with fixed stuff, 01 async e1, others reserved
// [RULE2] z5 from its value register when select is 0, from serial pin when 1
// [RULE3] z4 from its value register when select is 0, from serial pin when 1
// [RULE4] z3 from its value register when select is 0, from serial pin when 1
// [RULE5] h4 from its value register when select is 0, from serial pin when 1
// [RULE6] f2 from its value register when select is 0, from serial pin when 1
// [RULE7] g1 rei: 00/11 receive b3 errors, 01 g1 register, 10 serial pin
// [RULE8] g1 rdi: 00/11 receive alarms, 01 g1 register, 10 serial pin
// [RULE9] c2 from its value register when select is 0, from serial pin when 1
// [RULE10] auto mode writes 0xfc into c2 while au-ais is received
// [RULE11] forced au-ais sets h1, h2, h3 and all vc-3 bytes to ones
// [RULE12] forced payload defect code overrides the chosen c2 source
`timescale 1ns/10ps
`default_nettype none
module poh_insert_ctrl #(
  parameter int unsigned ADDR_W = poh_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic in_valid,
  input wire poh_pkg::beat_t in_beat,
  input wire logic path_overhead_serial_input,
  input wire logic oh_bit_en,
  input wire logic oh_sync,
  input wire logic [3:0] rx_rei,
  input wire logic [2:0] rx_rdi,
  input wire logic rx_au_ais,
  output logic out_valid,
  output poh_pkg::beat_t out_beat,
  output poh_pkg::payload_type_t payload_type
);
  typedef struct packed {
    poh_pkg::payload_type_t pt;
    logic [3:0] gb;
    logic [7:0] src;
    logic [7:0] c2;
    logic [7:0] g1;
    logic [7:0] f2;
    logic [7:0] h4;
    logic [7:0] z3;
    logic [7:0] z4;
    logic [7:0] z5;
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
    logic out_valid;
    poh_pkg::beat_t out;
  } state_t;

  state_t s;
  state_t n;
  logic [7:0] oh_byte;
  logic [12:0] wdec;
  logic [12:0] rdec;
  logic pdi_active;

  initial begin
    if (ADDR_W < 14 || ADDR_W > 32) begin
      $error("poh_insert_ctrl: ADDR_W must lie in 14..32");
    end
  end

  // returns {mapped, index}; only aligned words in the index range map
  function automatic logic [12:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a >> 2;
    decode = {(a[1:0] == 2'b00) && ((w >> 12) == '0), w[11:0]};
  endfunction

  function automatic logic [7:0] pick(input logic pin_sel, input logic [7:0] regv,
                                      input logic [7:0] pin);
    pick = pin_sel ? pin : regv;
  endfunction

  oh_deser #(
    .W(8)
  ) u_deser (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_in(path_overhead_serial_input),
    .bit_en(oh_bit_en),
    .sync(oh_sync),
    .byte_q(oh_byte)
  );

  assign wdec = decode(s.waddr);
  assign rdec = decode(araddr);
  assign pdi_active = s.src[poh_pkg::SRC_AUTO] && rx_au_ais;

  always_comb begin
    n = s;
    // write address and data are taken independently
    if (s.awready && awvalid) begin
      n.awready = 1'b0;
      n.aw_have = 1'b1;
      n.waddr = awaddr;
    end
    if (s.wready && wvalid) begin
      n.wready = 1'b0;
      n.w_have = 1'b1;
      n.wbyte = wdata[7:0];
      n.wen = wstrb[0];
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = poh_pkg::RESP_OKAY;
      if (!wdec[12]) begin
        n.bresp = poh_pkg::RESP_SLVERR;
      end else if (s.wen) begin
        unique case (wdec[11:0])
          poh_pkg::IDX_PAYLOAD: n.pt = poh_pkg::payload_type_t'(s.wbyte[1:0]); // RULE1
          poh_pkg::IDX_GROWTH: n.gb = s.wbyte[3:0];
          poh_pkg::IDX_SRC: n.src = s.wbyte;
          poh_pkg::IDX_C2: n.c2 = s.wbyte;
          poh_pkg::IDX_G1: n.g1 = s.wbyte;
          poh_pkg::IDX_F2: n.f2 = s.wbyte;
          poh_pkg::IDX_H4: n.h4 = s.wbyte;
          poh_pkg::IDX_Z3: n.z3 = s.wbyte;
          poh_pkg::IDX_Z4: n.z4 = s.wbyte;
          poh_pkg::IDX_Z5: n.z5 = s.wbyte;
          poh_pkg::IDX_STATUS: n.bresp = poh_pkg::RESP_OKAY;
          default: n.bresp = poh_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    // one read at a time; data answer one cycle after the address is taken
    if (s.arready && arvalid) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = poh_pkg::RESP_OKAY;
      n.rbyte = poh_pkg::RST_BYTE;
      if (!rdec[12]) begin
        n.rresp = poh_pkg::RESP_SLVERR;
      end else begin
        unique case (rdec[11:0])
          poh_pkg::IDX_PAYLOAD: n.rbyte = {6'h00, s.pt} & poh_pkg::PT_MASK;
          poh_pkg::IDX_GROWTH: n.rbyte = {4'h0, s.gb} & poh_pkg::GB_MASK;
          poh_pkg::IDX_SRC: n.rbyte = s.src;
          poh_pkg::IDX_C2: n.rbyte = s.c2;
          poh_pkg::IDX_G1: n.rbyte = s.g1;
          poh_pkg::IDX_F2: n.rbyte = s.f2;
          poh_pkg::IDX_H4: n.rbyte = s.h4;
          poh_pkg::IDX_Z3: n.rbyte = s.z3;
          poh_pkg::IDX_Z4: n.rbyte = s.z4;
          poh_pkg::IDX_Z5: n.rbyte = s.z5;
          poh_pkg::IDX_STATUS: n.rbyte = {pdi_active, rx_rdi, rx_rei};
          default: n.rresp = poh_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    // one-stage overhead insertion on the outbound byte stream
    n.out_valid = in_valid;
    if (in_valid) begin
      n.out = in_beat;
      unique case (in_beat.kind)
        poh_pkg::K_Z5: n.out.data = pick(s.gb[poh_pkg::GB_Z5], s.z5, oh_byte); // RULE2
        poh_pkg::K_Z4: n.out.data = pick(s.gb[poh_pkg::GB_Z4], s.z4, oh_byte); // RULE3
        poh_pkg::K_Z3: n.out.data = pick(s.gb[poh_pkg::GB_Z3], s.z3, oh_byte); // RULE4
        poh_pkg::K_H4: n.out.data = pick(s.gb[poh_pkg::GB_H4], s.h4, oh_byte); // RULE5
        poh_pkg::K_F2: n.out.data = pick(s.src[poh_pkg::SRC_F2], s.f2, oh_byte); // RULE6
        poh_pkg::K_C2: begin
          n.out.data = pick(s.src[poh_pkg::SRC_C2], s.c2, oh_byte); // RULE9
          if (pdi_active) begin
            n.out.data = poh_pkg::PDI_CODE; // RULE10 RULE12
          end
        end
        poh_pkg::K_G1: begin
          unique case (poh_pkg::g1_src_t'(s.src[poh_pkg::SRC_REI_LSB +: 2]))
            poh_pkg::G1_REG: n.out.data[poh_pkg::G1_REI_LSB +: 4] = s.g1[7:4]; // RULE7
            poh_pkg::G1_PIN: n.out.data[poh_pkg::G1_REI_LSB +: 4] = oh_byte[7:4]; // RULE7
            default: n.out.data[poh_pkg::G1_REI_LSB +: 4] = rx_rei; // RULE7
          endcase
          unique case (poh_pkg::g1_src_t'(s.src[poh_pkg::SRC_RDI_LSB +: 2]))
            poh_pkg::G1_REG: n.out.data[poh_pkg::G1_RDI_LSB +: 3] = s.g1[3:1]; // RULE8
            poh_pkg::G1_PIN: n.out.data[poh_pkg::G1_RDI_LSB +: 3] = oh_byte[3:1]; // RULE8
            default: n.out.data[poh_pkg::G1_RDI_LSB +: 3] = rx_rdi; // RULE8
          endcase
        end
        default: n.out.data = in_beat.data;
      endcase
      // forced au-ais wins over every source, transport overhead passes untouched
      if (s.src[poh_pkg::SRC_AIS] && in_beat.kind != poh_pkg::K_TOH) begin
        n.out.data = poh_pkg::AIS_BYTE; // RULE11
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {24'h000000, s.rbyte};
  assign out_valid = s.out_valid;
  assign out_beat = s.out;
  assign payload_type = s.pt;

  // helpers read only by the checks below
  logic [1:0] wb_pt;
  logic [3:0] g1_rei_val;
  logic [2:0] g1_rdi_val;
  logic [1:0] rei_sel;
  logic [1:0] rdi_sel;
  logic pt_write;
  assign wb_pt = s.wbyte[1:0];
  assign g1_rei_val = s.g1[7:4];
  assign g1_rdi_val = s.g1[3:1];
  assign rei_sel = s.src[6:5];
  assign rdi_sel = s.src[4:3];
  assign pt_write = s.aw_have && s.w_have && !s.bvalid && s.wen
                    && wdec == {1'b1, poh_pkg::IDX_PAYLOAD};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_payload_type;
    pt_write |=> payload_type == $past(wb_pt) && bvalid;
  endproperty
  a_payload_type: assert property (p_payload_type) // RULE1
    else $error("payload type not taken from write");

  property p_z5_reg;
    in_valid && in_beat.kind == poh_pkg::K_Z5 && !s.gb[3] && !s.src[0]
      |=> out_valid && out_beat.data == $past(s.z5);
  endproperty
  a_z5_reg: assert property (p_z5_reg) // RULE2
    else $error("z5 not from value register");

  property p_z4_pin;
    in_valid && in_beat.kind == poh_pkg::K_Z4 && s.gb[2] && !s.src[0]
      |=> out_beat.data == $past(oh_byte);
  endproperty
  a_z4_pin: assert property (p_z4_pin) // RULE3
    else $error("z4 not from serial pin");

  property p_f2_src;
    in_valid && in_beat.kind == poh_pkg::K_F2 && !s.src[0]
      |=> out_beat.data == ($past(s.src[7]) ? $past(oh_byte) : $past(s.f2));
  endproperty
  a_f2_src: assert property (p_f2_src) // RULE6
    else $error("f2 source wrong");

  property p_rei_reg;
    in_valid && in_beat.kind == poh_pkg::K_G1 && rei_sel == 2'b01 && !s.src[0]
      |=> out_beat.data[7:4] == $past(g1_rei_val);
  endproperty
  a_rei_reg: assert property (p_rei_reg) // RULE7
    else $error("g1 rei not from register");

  property p_rdi_rx;
    in_valid && in_beat.kind == poh_pkg::K_G1 && (rdi_sel == 2'b00 || rdi_sel == 2'b11)
      && !s.src[0] |=> out_beat.data[3:1] == $past(rx_rdi);
  endproperty
  a_rdi_rx: assert property (p_rdi_rx) // RULE8
    else $error("g1 rdi not from receive alarms");

  property p_c2_reg;
    in_valid && in_beat.kind == poh_pkg::K_C2 && !s.src[2] && !pdi_active && !s.src[0]
      |=> out_beat.data == $past(s.c2);
  endproperty
  a_c2_reg: assert property (p_c2_reg) // RULE9
    else $error("c2 not from value register");

  property p_pdi;
    in_valid && in_beat.kind == poh_pkg::K_C2 && s.src[1] && rx_au_ais && !s.src[0]
      |=> out_beat.data == 8'hfc;
  endproperty
  a_pdi: assert property (p_pdi) // RULE10
    else $error("c2 defect code missing");

  property p_pdi_over_pin;
    in_valid && in_beat.kind == poh_pkg::K_C2 && s.src[2] && pdi_active && !s.src[0]
      |=> out_valid && out_beat.data == poh_pkg::PDI_CODE;
  endproperty
  a_pdi_over_pin: assert property (p_pdi_over_pin) // RULE12
    else $error("pin c2 beat defect code");

  property p_ais;
    in_valid && s.src[0] && in_beat.kind != poh_pkg::K_TOH
      |=> out_valid && out_beat.data == 8'hff && out_beat.kind == $past(in_beat.kind);
  endproperty
  a_ais: assert property (p_ais) // RULE11
    else $error("forced au-ais byte not all ones");
endmodule
`default_nettype wire

// >>> tb/oh_source.sv
// serial overhead source model that shifts one byte msb first onto the overhead pin
`timescale 1ns/10ps
`default_nettype none
module oh_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic ser,
  output logic en,
  output logic sync,
  output logic busy
);
  logic [7:0] sh;
  logic [3:0] cnt;
  assign busy = (cnt != 4'h0) || en;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh <= 8'h00;
      cnt <= 4'h0;
      en <= 1'b0;
      sync <= 1'b0;
      ser <= 1'b0;
    end else if (go) begin
      sh <= byte_in;
      cnt <= 4'h8;
      en <= 1'b0;
      sync <= 1'b0;
      ser <= ~ser;
    end else if (cnt != 4'h0) begin
      en <= 1'b1;
      sync <= (cnt == 4'h8);
      ser <= sh[7];
      sh <= {sh[6:0], 1'b0};
      cnt <= cnt - 4'h1;
    end else begin
      en <= 1'b0;
      sync <= 1'b0;
      // unqualified line keeps toggling so a stale bit is never mistaken for data
      ser <= ~ser;
    end
  end
endmodule
`default_nettype wire

// >>> tb/vc3_path_overhead_insert_control_bench.sv
// self-checking bench for the path overhead insertion control
`timescale 1ns/10ps
`default_nettype none
module vc3_path_overhead_insert_control_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, out_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic in_valid = 1'b0;
  poh_pkg::beat_t in_beat = '0;
  poh_pkg::beat_t out_beat;
  poh_pkg::payload_type_t payload_type;
  logic ser, ser_en, ser_sync, busy;
  logic go = 1'b0;
  logic [7:0] ser_byte = 8'h00;
  logic [3:0] rx_rei = 4'h9;
  logic [2:0] rx_rdi = 3'h3;
  logic rx_au_ais = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [3:0] GK [4] = '{poh_pkg::K_Z5, poh_pkg::K_Z4, poh_pkg::K_Z3, poh_pkg::K_H4};
  localparam logic [11:0] GI [4] = '{poh_pkg::IDX_Z5, poh_pkg::IDX_Z4, poh_pkg::IDX_Z3,
    poh_pkg::IDX_H4};
  localparam logic [1:0] OK = poh_pkg::RESP_OKAY;

  always #12.5 aclk = ~aclk;

  poh_insert_ctrl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .in_valid(in_valid), .in_beat(in_beat),
    .path_overhead_serial_input(ser), .oh_bit_en(ser_en), .oh_sync(ser_sync),
    .rx_rei(rx_rei), .rx_rdi(rx_rdi), .rx_au_ais(rx_au_ais), .out_valid(out_valid),
    .out_beat(out_beat), .payload_type(payload_type));

  oh_source src (.aclk(aclk), .aresetn(aresetn), .go(go), .byte_in(ser_byte), .ser(ser),
    .en(ser_en), .sync(ser_sync), .busy(busy));

  function automatic logic [15:0] adr(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task close_out;
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er,
          input logic [3:0] s = 4'h1);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task beat(input logic [3:0] k, input logic [7:0] d, input logic [7:0] e);
    @(posedge aclk);
    in_valid <= 1'b1;
    in_beat <= poh_pkg::beat_t'({k, d});
    @(posedge aclk);
    in_valid <= 1'b0;
    #1;
    chk({31'h0, out_valid}, 32'h1);
    chk({20'h0, out_beat}, {20'h0, k, e});
  endtask

  task ser_send(input logic [7:0] b);
    @(posedge aclk);
    go <= 1'b1;
    ser_byte <= b;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask

  task t_regs;
    chk({30'h0, payload_type}, 32'h0);
    rd(adr(poh_pkg::IDX_PAYLOAD), 32'h0, OK);
    rd(adr(poh_pkg::IDX_GROWTH), 32'h0, OK);
    rd(adr(poh_pkg::IDX_SRC), 32'h0, OK);
    rd(16'h0004, 32'h0, poh_pkg::RESP_SLVERR);
    wr(16'h0006, 8'h55, poh_pkg::RESP_SLVERR);
    wr(adr(poh_pkg::IDX_C2), 8'h77, OK, 4'h0);
    rd(adr(poh_pkg::IDX_C2), 32'h0, OK);
    wr(adr(poh_pkg::IDX_GROWTH), 8'hff, OK);
    rd(adr(poh_pkg::IDX_GROWTH), 32'h0f, OK);
  endtask

  task t_payload;
    for (int i = 0; i < 4; i++) begin
      wr(adr(poh_pkg::IDX_PAYLOAD), 8'hfc | 8'(i), OK);
      rd(adr(poh_pkg::IDX_PAYLOAD), 32'(i), OK);
      chk({30'h0, payload_type}, 32'(i));
    end
  endtask

  task t_growth;
    for (int i = 0; i < 4; i++) wr(adr(GI[i]), 8'h50 + 8'(i), OK);
    wr(adr(poh_pkg::IDX_GROWTH), 8'h00, OK);
    for (int i = 0; i < 4; i++) beat(GK[i], 8'h11, 8'h50 + 8'(i));
    for (int i = 0; i < 4; i++) begin
      ser_send(8'ha0 + 8'(i));
      wr(adr(poh_pkg::IDX_GROWTH), 8'h08 >> i, OK);
      beat(GK[i], 8'h11, 8'ha0 + 8'(i));
      beat(GK[(i + 1) % 4], 8'h11, 8'h50 + 8'((i + 1) % 4));
    end
    wr(adr(poh_pkg::IDX_GROWTH), 8'h00, OK);
  endtask

  task t_f2_c2;
    wr(adr(poh_pkg::IDX_F2), 8'h3c, OK);
    wr(adr(poh_pkg::IDX_C2), 8'h13, OK);
    ser_send(8'h6a);
    wr(adr(poh_pkg::IDX_SRC), 8'h00, OK);
    beat(poh_pkg::K_F2, 8'h00, 8'h3c);
    beat(poh_pkg::K_C2, 8'h00, 8'h13);
    wr(adr(poh_pkg::IDX_SRC), 8'h80, OK);
    beat(poh_pkg::K_F2, 8'h00, 8'h6a);
    beat(poh_pkg::K_C2, 8'h00, 8'h13);
    wr(adr(poh_pkg::IDX_SRC), 8'h04, OK);
    beat(poh_pkg::K_F2, 8'h00, 8'h3c);
    beat(poh_pkg::K_C2, 8'h00, 8'h6a);
  endtask

  task t_g1;
    logic [3:0] rei;
    logic [2:0] rdi;
    wr(adr(poh_pkg::IDX_G1), 8'hb4, OK);
    ser_send(8'h5a);
    for (int r = 0; r < 4; r++) begin
      for (int d = 0; d < 4; d++) begin
        rei = (r == 1) ? 4'hb : (r == 2) ? 4'h5 : rx_rei;
        rdi = (d == 1) ? 3'h2 : (d == 2) ? 3'h5 : rx_rdi;
        wr(adr(poh_pkg::IDX_SRC), {1'b0, 2'(r), 2'(d), 3'h0}, OK);
        beat(poh_pkg::K_G1, 8'he1, {rei, rdi, 1'b1});
      end
    end
  endtask

  task t_pdi;
    wr(adr(poh_pkg::IDX_C2), 8'h27, OK);
    wr(adr(poh_pkg::IDX_SRC), 8'h06, OK);
    beat(poh_pkg::K_C2, 8'h00, 8'h5a);
    @(posedge aclk);
    rx_au_ais <= 1'b1;
    beat(poh_pkg::K_C2, 8'h00, poh_pkg::PDI_CODE);
    wr(adr(poh_pkg::IDX_SRC), 8'h02, OK);
    rd(adr(poh_pkg::IDX_STATUS), 32'hb9, OK);
    beat(poh_pkg::K_C2, 8'h00, poh_pkg::PDI_CODE);
    wr(adr(poh_pkg::IDX_SRC), 8'h00, OK);
    beat(poh_pkg::K_C2, 8'h00, 8'h27);
  endtask

  task t_ais;
    wr(adr(poh_pkg::IDX_SRC), 8'h03, OK);
    for (int k = 0; k < 12; k++)
      beat(4'(k), 8'h42, (k == 0) ? 8'h42 : poh_pkg::AIS_BYTE);
    wr(adr(poh_pkg::IDX_SRC), 8'h00, OK);
    @(posedge aclk);
    rx_au_ais <= 1'b0;
    beat(poh_pkg::K_PAYLOAD, 8'h42, 8'h42);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_payload;
    t_growth;
    t_f2_c2;
    t_g1;
    t_pdi;
    t_ais;
    close_out;
  end
endmodule
`default_nettype wire
